/* File: core/bcbc_top.sv */
// The AHB-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
// Summary of operation
// - Four 32-bit read/write channel B registers, all cleared on reset.
// - Compare address comes from one of four buses chosen by select bits.
// - L or I bus: full 32-bit address against full compare address.
// - X bus: address 15:1 against compare 31:17; compare 16:0 ignored.
// - Y bus: address 15:1 against compare 15:1; 31:16 and bit 0 ignored.
// - Address mask bit 1 excludes that address bit, 0 includes it.
// - L or I bus: full 32-bit data against full compare data.
// - X bus: data 15:0 against compare data 31:16; low half ignored.
// - Y bus: data 15:0 against compare data 15:0; high half ignored.
// - Data mask bit 1 excludes that data bit, 0 includes it.
// - Cycle-bus select 00 none, 01 L bus, 10 I bus, 11 L bus.
// - Memory-bus enable acts only with L selected; choice 0 X, 1 Y.
module bcbc_top (
  // Clock and reset
  input  wire logic                    hclk,
  input  wire logic                    hresetn,
  // AHB-Lite register slave
  input  wire bcbc_pkg::bcbc_ahb_req_t ahb_req,
  output bcbc_pkg::bcbc_ahb_rsp_t      ahb_rsp,
  // Monitored CPU buses
  input  wire bcbc_pkg::bcbc_cpu_bus_t cpu_bus,
  // Channel B match results
  output logic                         addr_match,
  output logic                         data_match
);
  import bcbc_pkg::*;

  bcbc_state_t s_q;
  bcbc_state_t s_d;
  bcbc_bus_t   sel_bus;
  logic [1:0]  cyc_bus;
  logic        sel_valid;
  logic [31:0] obs_addr;
  logic [31:0] obs_data;
  logic [31:0] amask_eff;
  logic [31:0] dmask_eff;
  logic        addr_eq;
  logic        data_eq;
  logic        acc;
  logic [7:0]  acc_ofs;

  // ==========================================================================
  // Bus selection
  // ==========================================================================
  assign cyc_bus = s_q.chan_b_cycle_condition[BCBC_CDB_HI:BCBC_CDB_LO];

  always_comb
  begin
    sel_bus = BCBC_BUS_NONE;
    unique case (cyc_bus)
      BCBC_CDB_NONE:
        sel_bus = BCBC_BUS_NONE;
      BCBC_CDB_I:
        sel_bus = BCBC_BUS_I;
      BCBC_CDB_L, BCBC_CDB_L_ALT:
      begin
        // Memory buses only reachable through the L bus setting
        if (s_q.chan_b_cycle_condition[BCBC_XYE_BIT])
          sel_bus = s_q.chan_b_cycle_condition[BCBC_XYS_BIT] ? BCBC_BUS_Y : BCBC_BUS_X;
        else
          sel_bus = BCBC_BUS_L;
      end
    endcase
  end

  // ==========================================================================
  // Operand alignment and forced masks
  // ==========================================================================
  always_comb
  begin
    sel_valid = 1'b0;
    obs_addr  = 32'h0000_0000;
    obs_data  = 32'h0000_0000;
    amask_eff = s_q.chan_b_address_mask;
    dmask_eff = s_q.chan_b_data_mask;
    unique case (sel_bus)
      BCBC_BUS_NONE:
        sel_valid = 1'b0;
      BCBC_BUS_L:
      begin
        sel_valid = cpu_bus.local_cycle;
        obs_addr  = cpu_bus.local_address_bus;
        obs_data  = cpu_bus.local_data_bus;
      end
      BCBC_BUS_I:
      begin
        sel_valid = cpu_bus.instr_cycle;
        obs_addr  = cpu_bus.instr_side_address_bus;
        obs_data  = cpu_bus.instr_side_data_bus;
      end
      BCBC_BUS_X:
      begin
        sel_valid       = cpu_bus.x_cycle;
        obs_addr[31:17] = cpu_bus.x_memory_address_bus[15:1];
        amask_eff[16:0] = 17'h1ffff;
        obs_data[31:16] = cpu_bus.x_memory_data_bus;
        dmask_eff[15:0] = 16'hffff;
      end
      BCBC_BUS_Y:
      begin
        sel_valid        = cpu_bus.y_cycle;
        obs_addr[15:1]   = cpu_bus.y_memory_address_bus[15:1];
        amask_eff[31:16] = 16'hffff;
        amask_eff[0]     = 1'b1;
        obs_data[15:0]   = cpu_bus.y_memory_data_bus;
        dmask_eff[31:16] = 16'hffff;
      end
      default:
        sel_valid = 1'b0;
    endcase
  end

  // ==========================================================================
  // Masked comparators
  // ==========================================================================
  bcbc_mask_cmp #(
    .WIDTH    (32)
  ) u_addr_cmp (
    .observed (obs_addr),
    .compare  (s_q.chan_b_compare_address),
    .mask     (amask_eff),
    .equal    (addr_eq)
  );

  bcbc_mask_cmp #(
    .WIDTH    (32)
  ) u_data_cmp (
    .observed (obs_data),
    .compare  (s_q.chan_b_compare_data),
    .mask     (dmask_eff),
    .equal    (data_eq)
  );

  // ==========================================================================
  // Next state: register file, AHB slave, match flags
  // ==========================================================================
  assign acc     = ahb_req.hsel & ahb_req.hready & ahb_req.htrans[BCBC_HTRANS_ACTIVE];
  assign acc_ofs = ahb_req.haddr[7:0];

  always_comb
  begin
    s_d = s_q;
    // Data phase of a write lands before the next read is decoded,
    // so a read right behind a write sees the new word
    if (s_q.wr_pend)
    begin
      unique case (s_q.wr_ofs)
        BCBC_OFS_CMP_ADDR:  s_d.chan_b_compare_address = ahb_req.hwdata;
        BCBC_OFS_ADDR_MASK: s_d.chan_b_address_mask    = ahb_req.hwdata;
        BCBC_OFS_CMP_DATA:  s_d.chan_b_compare_data    = ahb_req.hwdata;
        BCBC_OFS_DATA_MASK: s_d.chan_b_data_mask       = ahb_req.hwdata;
        BCBC_OFS_CYC_COND:
          s_d.chan_b_cycle_condition = ahb_req.hwdata[15:0] & BCBC_CYC_WMASK;
        default: s_d.wr_pend = 1'b0;
      endcase
    end
    s_d.wr_pend       = acc & ahb_req.hwrite;
    s_d.wr_ofs        = acc_ofs;
    s_d.rsp.hreadyout = 1'b1;
    s_d.rsp.hresp     = BCBC_HRESP_OKAY;
    s_d.rsp.hrdata    = 32'h0000_0000;
    if (acc && !ahb_req.hwrite)
    begin
      unique case (acc_ofs)
        BCBC_OFS_CMP_ADDR:  s_d.rsp.hrdata = s_d.chan_b_compare_address;
        BCBC_OFS_ADDR_MASK: s_d.rsp.hrdata = s_d.chan_b_address_mask;
        BCBC_OFS_CMP_DATA:  s_d.rsp.hrdata = s_d.chan_b_compare_data;
        BCBC_OFS_DATA_MASK: s_d.rsp.hrdata = s_d.chan_b_data_mask;
        BCBC_OFS_CYC_COND:  s_d.rsp.hrdata = {16'h0000, s_d.chan_b_cycle_condition};
        BCBC_OFS_STATUS:
        begin
          s_d.rsp.hrdata[BCBC_STS_AMATCH]                   = s_q.addr_match;
          s_d.rsp.hrdata[BCBC_STS_DMATCH]                   = s_q.data_match;
          s_d.rsp.hrdata[BCBC_STS_BUS_LO+2:BCBC_STS_BUS_LO] = s_q.last_bus;
        end
        default: s_d.rsp.hrdata = 32'h0000_0000;
      endcase
    end
    // One-cycle report of the bus cycle just observed
    s_d.addr_match = sel_valid & addr_eq;
    s_d.data_match = sel_valid & data_eq;
    s_d.last_bus   = sel_bus;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      s_q.chan_b_compare_address <= BCBC_RST_WORD;
      s_q.chan_b_address_mask    <= BCBC_RST_WORD;
      s_q.chan_b_compare_data    <= BCBC_RST_WORD;
      s_q.chan_b_data_mask       <= BCBC_RST_WORD;
      s_q.chan_b_cycle_condition <= BCBC_RST_CYC_COND;
      s_q.wr_pend                <= 1'b0;
      s_q.wr_ofs                 <= 8'h00;
      s_q.rsp.hreadyout          <= 1'b1;
      s_q.rsp.hresp              <= BCBC_HRESP_OKAY;
      s_q.rsp.hrdata             <= BCBC_RST_WORD;
      s_q.addr_match             <= 1'b0;
      s_q.data_match             <= 1'b0;
      s_q.last_bus               <= BCBC_BUS_NONE;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign ahb_rsp    = s_q.rsp;
  assign addr_match = s_q.addr_match;
  assign data_match = s_q.data_match;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence wr_addr_s;
    acc && ahb_req.hwrite && (acc_ofs == BCBC_OFS_CMP_ADDR);
  endsequence

  sequence wr_dmask_s;
    acc && ahb_req.hwrite && (acc_ofs == BCBC_OFS_DATA_MASK);
  endsequence

  sequence rd_back_s;
    acc && !ahb_req.hwrite && (acc_ofs == BCBC_OFS_CMP_ADDR);
  endsequence

  reg_write_a: assert property (wr_addr_s ##1 1'b1 |=>
      s_q.chan_b_compare_address == $past(ahb_req.hwdata))
    else $error("compare address write not stored");

  reg_readback_a: assert property (rd_back_s ##1 1'b1 |->
      ahb_rsp.hrdata == $past(s_d.chan_b_compare_address, 1))
    else $error("compare address read data wrong");

  dmask_write_a: assert property (wr_dmask_s ##1 1'b1 |=>
      s_q.chan_b_data_mask == $past(ahb_req.hwdata))
    else $error("data mask write not stored");

  no_compare_a: assert property ((cyc_bus == BCBC_CDB_NONE) |=>
      !addr_match && !data_match)
    else $error("match flagged with comparison off");

  istay_a: assert property ((cyc_bus == BCBC_CDB_I) |->
      sel_bus == BCBC_BUS_I)
    else $error("memory bus chosen while I bus selected");

  l_full_a: assert property ((sel_bus == BCBC_BUS_L) && cpu_bus.local_cycle &&
      (cpu_bus.local_address_bus == s_q.chan_b_compare_address) |=> addr_match)
    else $error("full L address equal but no match");

  x_addr_a: assert property ((sel_bus == BCBC_BUS_X) && cpu_bus.x_cycle &&
      ((cpu_bus.x_memory_address_bus[15:1] ^ s_q.chan_b_compare_address[31:17])
        & ~s_q.chan_b_address_mask[31:17]) == 15'h0000 |=> addr_match)
    else $error("X address alignment wrong");

  y_addr_a: assert property ((sel_bus == BCBC_BUS_Y) && cpu_bus.y_cycle &&
      ((cpu_bus.y_memory_address_bus[15:1] ^ s_q.chan_b_compare_address[15:1])
        & ~s_q.chan_b_address_mask[15:1]) != 15'h0000 |=> !addr_match)
    else $error("Y address mismatch still matched");

  amask_all_a: assert property (sel_valid && (s_q.chan_b_address_mask == 32'hffff_ffff)
      |=> addr_match)
    else $error("fully masked address did not match");

  i_data_a: assert property ((sel_bus == BCBC_BUS_I) && cpu_bus.instr_cycle &&
      (s_q.chan_b_data_mask == 32'h0000_0000) &&
      (cpu_bus.instr_side_data_bus != s_q.chan_b_compare_data) |=> !data_match)
    else $error("I data mismatch still matched");

  x_data_a: assert property ((sel_bus == BCBC_BUS_X) && cpu_bus.x_cycle &&
      (s_q.chan_b_data_mask[31:16] == 16'h0000) &&
      (cpu_bus.x_memory_data_bus == s_q.chan_b_compare_data[31:16]) |=> data_match)
    else $error("X data alignment wrong");

  y_data_a: assert property ((sel_bus == BCBC_BUS_Y) && cpu_bus.y_cycle &&
      (s_q.chan_b_data_mask[15:0] == 16'h0000) &&
      (cpu_bus.y_memory_data_bus == s_q.chan_b_compare_data[15:0]) |=> data_match)
    else $error("Y data alignment wrong");

  match_cause_a: assert property ($rose(addr_match) || $rose(data_match) |->
      $past(sel_valid))
    else $error("match without a selected bus cycle");

  ready_okay_a: assert property (ahb_rsp.hreadyout && (ahb_rsp.hresp == BCBC_HRESP_OKAY))
    else $error("slave stalled or answered with error");

endmodule // bcbc_top

/* File: core/bcbc_pkg.sv */
package bcbc_pkg;

  // ==========================================================================
  // Register map, byte offsets on the AHB-Lite slave
  // ==========================================================================
  localparam logic [7:0]  BCBC_OFS_CMP_ADDR  = 8'h00;
  localparam logic [7:0]  BCBC_OFS_ADDR_MASK = 8'h04;
  localparam logic [7:0]  BCBC_OFS_CMP_DATA  = 8'h08;
  localparam logic [7:0]  BCBC_OFS_DATA_MASK = 8'h0c;
  localparam logic [7:0]  BCBC_OFS_CYC_COND  = 8'h10;
  localparam logic [7:0]  BCBC_OFS_STATUS    = 8'h14;

  // ==========================================================================
  // Reset values and field layout
  // ==========================================================================
  localparam logic [31:0] BCBC_RST_WORD      = 32'h0000_0000;
  localparam logic [15:0] BCBC_RST_CYC_COND  = 16'h0000;
  localparam logic [15:0] BCBC_CYC_WMASK     = 16'h03ff;
  localparam int unsigned BCBC_CDB_LO        = 6;
  localparam int unsigned BCBC_CDB_HI        = 7;
  localparam int unsigned BCBC_XYS_BIT       = 8;
  localparam int unsigned BCBC_XYE_BIT       = 9;
  localparam int unsigned BCBC_STS_AMATCH    = 0;
  localparam int unsigned BCBC_STS_DMATCH    = 1;
  localparam int unsigned BCBC_STS_BUS_LO    = 2;

  // Cycle-bus select codes
  localparam logic [1:0]  BCBC_CDB_NONE      = 2'b00;
  localparam logic [1:0]  BCBC_CDB_L         = 2'b01;
  localparam logic [1:0]  BCBC_CDB_I         = 2'b10;
  localparam logic [1:0]  BCBC_CDB_L_ALT     = 2'b11;

  // AHB transfer type bit that marks NONSEQ or SEQ
  localparam int unsigned BCBC_HTRANS_ACTIVE = 1;
  localparam logic        BCBC_HRESP_OKAY    = 1'b0;

  typedef enum logic [2:0] {
    BCBC_BUS_NONE = 3'b000,
    BCBC_BUS_L    = 3'b001,
    BCBC_BUS_I    = 3'b010,
    BCBC_BUS_X    = 3'b011,
    BCBC_BUS_Y    = 3'b100
  } bcbc_bus_t;

  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } bcbc_ahb_req_t;

  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
  } bcbc_ahb_rsp_t;

  typedef struct packed {
    logic        local_cycle;
    logic [31:0] local_address_bus;
    logic [31:0] local_data_bus;
    logic        instr_cycle;
    logic [31:0] instr_side_address_bus;
    logic [31:0] instr_side_data_bus;
    logic        x_cycle;
    logic [15:0] x_memory_address_bus;
    logic [15:0] x_memory_data_bus;
    logic        y_cycle;
    logic [15:0] y_memory_address_bus;
    logic [15:0] y_memory_data_bus;
  } bcbc_cpu_bus_t;

  typedef struct packed {
    logic [31:0]   chan_b_compare_address;
    logic [31:0]   chan_b_address_mask;
    logic [31:0]   chan_b_compare_data;
    logic [31:0]   chan_b_data_mask;
    logic [15:0]   chan_b_cycle_condition;
    logic          wr_pend;
    logic [7:0]    wr_ofs;
    bcbc_ahb_rsp_t rsp;
    logic          addr_match;
    logic          data_match;
    bcbc_bus_t     last_bus;
  } bcbc_state_t;

endpackage

/* File: core/bcbc_mask_cmp.sv */
`timescale 1ns/10ps
module bcbc_mask_cmp #(
  parameter int unsigned WIDTH = 32
) (
  // Operands
  input  wire logic [WIDTH-1:0] observed,
  input  wire logic [WIDTH-1:0] compare,
  input  wire logic [WIDTH-1:0] mask,
  // Result
  output logic                  equal
);
  logic [WIDTH-1:0] hit;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      // A set mask bit drops this position out of the match
      assign hit[g] = mask[g] | (observed[g] == compare[g]);
    end
  endgenerate

  assign equal = &hit;
endmodule // bcbc_mask_cmp

/* File: verification/bcbc_cpu_model.sv */
`timescale 1ns/10ps
module bcbc_cpu_model (
  // Clock and reset
  input  wire logic                hclk,
  input  wire logic                hresetn,
  // Cycle request from the bench
  input  wire bcbc_pkg::bcbc_bus_t kind,
  input  wire logic                strobe,
  input  wire logic [31:0]         addr,
  input  wire logic [31:0]         data,
  // Monitored buses
  output bcbc_pkg::bcbc_cpu_bus_t  cpu_bus
);
  import bcbc_pkg::*;

  // ==========================================================================
  // Idle pattern
  // ==========================================================================
  // Buses not in use churn every cycle, so a stale value never matches by luck
  logic [31:0] idle_q;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      idle_q <= 32'h5a5a_c3c3;
    else
      idle_q <= {idle_q[30:0], idle_q[31] ^ idle_q[21] ^ idle_q[1] ^ idle_q[0]};
  end

  // ==========================================================================
  // Bus drive
  // ==========================================================================
  always_comb
  begin
    cpu_bus = {idle_q[0], idle_q, ~idle_q, idle_q[1], ~idle_q, idle_q, idle_q[2],
               idle_q[15:0], idle_q[31:16], idle_q[3], idle_q[31:16], idle_q[15:0]};
    case (kind)
      BCBC_BUS_L:
      begin
        cpu_bus.local_cycle = strobe;
        cpu_bus.local_address_bus = addr;
        cpu_bus.local_data_bus = data;
      end
      BCBC_BUS_I:
      begin
        cpu_bus.instr_cycle = strobe;
        cpu_bus.instr_side_address_bus = addr;
        cpu_bus.instr_side_data_bus = data;
      end
      BCBC_BUS_X:
      begin
        cpu_bus.x_cycle = strobe;
        cpu_bus.x_memory_address_bus = addr[15:0];
        cpu_bus.x_memory_data_bus = data[15:0];
      end
      BCBC_BUS_Y:
      begin
        cpu_bus.y_cycle = strobe;
        cpu_bus.y_memory_address_bus = addr[15:0];
        cpu_bus.y_memory_data_bus = data[15:0];
      end
      default:
      begin
      end
    endcase
  end
endmodule // bcbc_cpu_model

/* File: verification/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  import bcbc_pkg::*;

  // ==========================================================================
  // Signals
  // ==========================================================================
  logic          hclk;
  logic          hresetn;
  bcbc_ahb_req_t req;
  wire bcbc_ahb_req_t ahb_in;
  bcbc_ahb_rsp_t ahb_rsp;
  bcbc_cpu_bus_t cpu_bus;
  bcbc_bus_t     kind;
  logic          strobe;
  logic [31:0]   addr;
  logic [31:0]   data;
  logic          addr_match;
  logic          data_match;
  logic [31:0]   lfsr;
  int            miscompares;
  int            checks;

  // Single slave: its hreadyout is the bus hready
  assign ahb_in = {req[$bits(bcbc_ahb_req_t)-1:1], ahb_rsp.hreadyout};

  bcbc_top dut_u (.hclk(hclk), .hresetn(hresetn), .ahb_req(ahb_in), .ahb_rsp(ahb_rsp),
                  .cpu_bus(cpu_bus), .addr_match(addr_match), .data_match(data_match));
  bcbc_cpu_model cpu_u (.hclk(hclk), .hresetn(hresetn), .kind(kind), .strobe(strobe),
                        .addr(addr), .data(data), .cpu_bus(cpu_bus));

  always #2.5 hclk = ~hclk;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], 1'b0} ^ (lfsr[31] ? 32'h04c1_1db7 : 32'h0);
    return lfsr;
  endfunction

  function automatic bcbc_bus_t sel_bus(input logic [15:0] c);
    if (c[7:6] == BCBC_CDB_NONE) return BCBC_BUS_NONE;
    if (c[7:6] == BCBC_CDB_I) return BCBC_BUS_I;
    if (!c[BCBC_XYE_BIT]) return BCBC_BUS_L;
    return c[BCBC_XYS_BIT] ? BCBC_BUS_Y : BCBC_BUS_X;
  endfunction

  // Compare value as it would appear on the chosen bus
  function automatic logic [31:0] proj(input bcbc_bus_t k, input logic [31:0] c, input logic a);
    if (k == BCBC_BUS_X) return a ? {16'h0, c[31:17], 1'b0} : {16'h0, c[31:16]};
    return c;
  endfunction

  function automatic logic hit(input bcbc_bus_t k, input logic s,
                               input logic [31:0] o, c, m, input logic a);
    logic [31:0] d;
    d = (o ^ c) & ~m;
    if (k == BCBC_BUS_X)
      d = a ? {(o[15:1] ^ c[31:17]) & ~m[31:17], 17'h0} : {(o[15:0] ^ c[31:16]) & ~m[31:16], 16'h0};
    if (k == BCBC_BUS_Y)
      d = a ? {16'h0, (o[15:1] ^ c[15:1]) & ~m[15:1], 1'b0} : {16'h0, (o[15:0] ^ c[15:0]) & ~m[15:0]};
    return s && k != BCBC_BUS_NONE && d == 32'h0;
  endfunction

  task automatic report_and_stop();
    $display("checks=%0d miscompares=%0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (ahb_rsp.hreadyout !== 1'b1 && n < 64);
    if (n >= 64)
    begin
      miscompares++;
      report_and_stop();
    end
  endtask

  task automatic ahb(input logic wr, input logic [7:0] ofs, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge hclk);
    req.hsel <= 1'b1;
    req.htrans <= 2'b10;
    req.haddr <= {24'h0, ofs};
    req.hwrite <= wr;
    req.hsize <= 3'b010;
    wait_ready();
    req.htrans <= 2'b00;
    req.hwdata <= wd;
    wait_ready();
    rd = ahb_rsp.hrdata;
  endtask

  task automatic trial(input logic [15:0] cond, input logic [31:0] ca, am, cd, dm);
    bcbc_bus_t k;
    logic [31:0] r, ra, rd;
    k = sel_bus(cond);
    r = rnd();
    ra = proj(k, ca, 1'b1) ^ (rnd() & proj(k, am, 1'b1)) ^ (r[2] ? 32'h1 << r[8:4] : 32'h0);
    rd = proj(k, cd, 1'b0) ^ (rnd() & proj(k, dm, 1'b0)) ^ (r[3] ? 32'h1 << r[13:9] : 32'h0);
    @(posedge hclk);
    kind <= (k == BCBC_BUS_NONE) ? BCBC_BUS_L : k;
    strobe <= r[0] | r[1];
    addr <= ra;
    data <= rd;
    @(posedge hclk);
    strobe <= 1'b0;
    #1;
    check({31'h0, addr_match}, {31'h0, hit(k, r[0] | r[1], ra, ca, am, 1'b1)});
    check({31'h0, data_match}, {31'h0, hit(k, r[0] | r[1], rd, cd, dm, 1'b0)});
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    logic [7:0]  ofs [5];
    logic [31:0] v [5];
    logic [15:0] cc [5];
    logic [31:0] rv;
    ofs = '{BCBC_OFS_CMP_ADDR, BCBC_OFS_ADDR_MASK, BCBC_OFS_CMP_DATA, BCBC_OFS_DATA_MASK,
            BCBC_OFS_CYC_COND};
    hclk = 1'b0;
    hresetn = 1'b0;
    req = '0;
    kind = BCBC_BUS_NONE;
    strobe = 1'b0;
    addr = 32'h0;
    data = 32'h0;
    lfsr = 32'd11;
    miscompares = 0;
    checks = 0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    for (int j = 0; j < 5; j++)
    begin
      ahb(1'b0, ofs[j], 32'h0, rv);
      check(rv, BCBC_RST_WORD);
    end
    $display("test reset values done");
    for (int i = 0; i < 16; i++)
    begin
      rv = rnd();
      // Size field longword whenever data is compared
      v[4] = {16'h0, rv[15:10], i[3:0], rv[5:2], 2'b11};
      v[0] = rnd();
      v[1] = rnd() & rnd() & rnd();
      v[2] = rnd();
      v[3] = rnd() & rnd() & rnd();
      for (int j = 0; j < 5; j++)
        ahb(1'b1, ofs[j], v[j], rv);
      for (int j = 0; j < 4; j++)
      begin
        ahb(1'b0, ofs[j], 32'h0, rv);
        check(rv, v[j]);
      end
      ahb(1'b0, ofs[4], 32'h0, rv);
      check(rv, v[4] & {16'h0, BCBC_CYC_WMASK});
      repeat (12) trial(v[4][15:0], v[0], v[1], v[2], v[3]);
      // No strobe since the trials: flags clear, bus field holds the selection
      ahb(1'b0, BCBC_OFS_STATUS, 32'h0, rv);
      check(rv, {27'h0, sel_bus(v[4][15:0]), 2'b00});
      $display("test bus select %0d done", i);
    end
    // Corners: full address mask, zero data mask, byte and word sizes
    cc = '{16'h0083, 16'h0243, 16'h0343, 16'h0041, 16'h0042};
    for (int j = 0; j < 5; j++)
    begin
      rv = rnd();
      v[4] = {16'h0, cc[j]};
      v[0] = rnd();
      v[1] = (j == 0) ? 32'hffff_ffff : 32'h0000_0000;
      v[2] = (j == 3) ? {rv[31:16], rv[7:0], rv[7:0]} : rv;
      v[3] = (j == 3) ? 32'h0000_0303 : 32'h0000_0000;
      if (j == 4)
      begin
        v[2] = {rv[31:16], 16'h0000};
        v[3] = 32'h000f_ffff;
      end
      for (int k = 0; k < 5; k++)
        ahb(1'b1, ofs[k], v[k], rv);
      repeat (12) trial(v[4][15:0], v[0], v[1], v[2], v[3]);
    end
    $display("test corner configurations done");
    ahb(1'b1, 8'h1c, 32'hdead_beef, rv);
    ahb(1'b0, 8'h1c, 32'h0, rv);
    check(rv, 32'h0);
    $display("test unmapped offset done");
    report_and_stop();
  end
endmodule // tb_top
